// file: pll_cfg_pkg.sv
// Package for the PLL spread and frequency-set configuration slice.
// Assumes APB with 32-bit data; printed offsets are register indexes.
package pll_cfg_pkg;
    localparam int ADDR_W = 10;
    // Register indexes; byte address is four times the index.
    localparam logic [7:0] IDX_P3_N_HIGH = 8'h3C;
    localparam logic [7:0] IDX_P3_N_LOW_R_HIGH = 8'h3D;
    localparam logic [7:0] IDX_P3_R_LOW_Q_HIGH = 8'h3E;
    localparam logic [7:0] IDX_P3_Q_LOW_P_BAND = 8'h3F;
    localparam logic [7:0] IDX_SPREAD_A = 8'h40;
    localparam logic [7:0] IDX_SPREAD_B = 8'h41;
    localparam logic [7:0] IDX_SPREAD_C = 8'h42;
    localparam logic [7:0] IDX_SET_SELECT = 8'h43;
    localparam logic [7:0] IDX_STATUS = 8'h44;
    localparam logic [7:0] IDX_LIMIT = 8'h50;
    // Reset values of the eight bytes.
    localparam logic [7:0] RST_P3_N_HIGH = 8'h00;
    localparam logic [7:0] RST_P3_N_LOW_R_HIGH = 8'h40;
    localparam logic [7:0] RST_P3_R_LOW_Q_HIGH = 8'h02;
    localparam logic [7:0] RST_P3_Q_LOW_P_BAND = 8'h08;
    localparam logic [7:0] RST_SPREAD = 8'h00;
    localparam logic [7:0] RST_SET_SELECT = 8'h00;
    // Field widths of the alternate third-PLL word, then the spread-code width and the setting count.
    localparam int N_W = 12;
    localparam int R_W = 9;
    localparam int Q_W = 6;
    localparam int P_W = 3;
    localparam int CODE_W = 3;
    localparam int SETTINGS = 8;
    // Field limits checked for software visibility.
    localparam logic [5:0] Q_MIN = 6'h10;
    // Spread amounts in hundredths of a percent.
    localparam logic [7:0] SPREAD_OFF = 8'h00;
    localparam logic [7:0] SPREAD_025 = 8'h19;
    localparam logic [7:0] SPREAD_050 = 8'h32;
    localparam logic [7:0] SPREAD_075 = 8'h4B;
    localparam logic [7:0] SPREAD_100 = 8'h64;
    localparam logic [7:0] SPREAD_125 = 8'h7D;
    localparam logic [7:0] SPREAD_150 = 8'h96;
    localparam logic [7:0] SPREAD_200 = 8'hC8;
    // Band thresholds in MHz.
    localparam logic [7:0] BAND_T1 = 8'h7D;
    localparam logic [7:0] BAND_T2 = 8'h96;
    localparam logic [7:0] BAND_T3 = 8'hAF;
    typedef enum logic [1:0] {BAND_LOW, BAND_MID, BAND_HIGH, BAND_TOP} vco_band_e;
endpackage

// file: pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes pins are asynchronous to mclk_in.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] synced_out
);
    logic [WIDTH-1:0] stage1;
    // First stage feeds only the second.
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage1 <= '0;
            synced_out <= '0;
        end else begin
            stage1 <= pins_in;
            synced_out <= stage1;
        end
    end
endmodule // pin_sync

// file: pll_ssc_freq_select_config.sv
// Configuration register slice with APB slave and pin-selected outputs.
// Assumes APB master per protocol and asynchronous setting pins.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module pll_ssc_freq_select_config
    import pll_cfg_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic setting_pin_lsb_in,
    input wire logic setting_pin_mid_in,
    input wire logic setting_pin_msb_in,
    input wire logic center_spread_in,
    output logic [N_W-1:0] third_pll_alt_mult_n_out,
    output logic [R_W-1:0] third_pll_alt_frac_r_out,
    output logic [Q_W-1:0] third_pll_alt_div_q_out,
    output logic [P_W-1:0] third_pll_alt_div_p_out,
    output logic [1:0] third_pll_alt_vco_band_out,
    output logic [2:0] active_setting_out,
    output logic [CODE_W-1:0] fourth_pll_spread_code_out,
    output logic [7:0] spread_amount_out,
    output logic center_spread_out,
    output logic fourth_pll_set_choice_out
);
    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Spread amount in hundredths of a percent for a code.
    function automatic logic [7:0] spread_amount(input logic [2:0] code);
        case (code)
            3'h0: spread_amount = SPREAD_OFF;
            3'h1: spread_amount = SPREAD_025;
            3'h2: spread_amount = SPREAD_050;
            3'h3: spread_amount = SPREAD_075;
            3'h4: spread_amount = SPREAD_100;
            3'h5: spread_amount = SPREAD_125;
            3'h6: spread_amount = SPREAD_150;
            default: spread_amount = SPREAD_200;
        endcase
    endfunction

    // Band code for a VCO frequency in MHz; offered for software tools.
    function automatic vco_band_e band_of(input logic [7:0] mhz);
        if (mhz < BAND_T1) begin
            band_of = BAND_LOW;
        end else if (mhz < BAND_T2) begin
            band_of = BAND_MID;
        end else if (mhz < BAND_T3) begin
            band_of = BAND_HIGH;
        end else begin
            band_of = BAND_TOP;
        end
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] regs [8];
    logic [7:0] next_regs [8];
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [7:0] idx;
    logic in_bank;
    logic [2:0] slot;
    logic [2:0] pins_sync;
    logic [23:0] spread_word;
    logic [29:0] alt_word;
    logic [2:0] next_active;
    logic [CODE_W-1:0] next_code;
    logic next_choice;
    logic n_bad;
    logic q_bad;
    logic setup;

    assign idx = paddr[9:2];
    assign setup = psel && !penable;
    assign in_bank = (idx >= IDX_P3_N_HIGH) && (idx <= IDX_SET_SELECT);
    assign slot = idx[2:0] ^ IDX_P3_N_HIGH[2:0];
    // The 30-bit word is the four bytes above the band field.
    assign alt_word = {regs[0], regs[1], regs[2], regs[3][7:2]};
    assign spread_word = {regs[4], regs[5], regs[6]};
    assign n_bad = (alt_word[29:18] == '0);
    assign q_bad = (alt_word[8:3] < Q_MIN);

    // Setting pins pass two flops first; center_spread_in is registered once, without the synchroniser.
    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .pins_in({setting_pin_msb_in, setting_pin_mid_in, setting_pin_lsb_in}),
        .synced_out(pins_sync)
    );

    // ------------------------------------------------------------
    // APB next-state logic
    // ------------------------------------------------------------
    // One wait state answers each transfer; a write lands at the completing edge.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_regs[i] = regs[i];
        end
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            next_prdata = '0;
            if (in_bank) begin
                if (!pwrite) begin
                    next_prdata = {24'h000000, regs[slot]};
                end
            end else if (idx == IDX_STATUS && !pwrite) begin
                next_prdata = {27'h0000000, q_bad, n_bad, active_setting_out};
            end else begin
                // Unmapped or beyond limit: errors, writes are dropped.
                next_pslverr = 1'b1;
            end
        end else if (setup) begin
            next_prdata = prdata;
        end
        // The write takes effect only where the master samples pready high.
        if (psel && penable && pready && pwrite && in_bank && pstrb[0]) begin
            next_regs[slot] = pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Active-setting selection
    // ------------------------------------------------------------
    // The pin index picks one code and one select bit.
    always_comb begin
        next_active = pins_sync;
        next_code = spread_word[pins_sync*CODE_W +: CODE_W];
        next_choice = regs[7][pins_sync];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // All state and outputs register here.
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            regs[0] <= RST_P3_N_HIGH;
            regs[1] <= RST_P3_N_LOW_R_HIGH;
            regs[2] <= RST_P3_R_LOW_Q_HIGH;
            regs[3] <= RST_P3_Q_LOW_P_BAND;
            regs[4] <= RST_SPREAD;
            regs[5] <= RST_SPREAD;
            regs[6] <= RST_SPREAD;
            regs[7] <= RST_SET_SELECT;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            third_pll_alt_mult_n_out <= '0;
            third_pll_alt_frac_r_out <= '0;
            third_pll_alt_div_q_out <= '0;
            third_pll_alt_div_p_out <= '0;
            third_pll_alt_vco_band_out <= '0;
            active_setting_out <= '0;
            fourth_pll_spread_code_out <= '0;
            spread_amount_out <= '0;
            center_spread_out <= 1'b0;
            fourth_pll_set_choice_out <= 1'b0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                regs[i] <= next_regs[i];
            end
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            third_pll_alt_mult_n_out <= alt_word[29:18];
            third_pll_alt_frac_r_out <= alt_word[17:9];
            third_pll_alt_div_q_out <= alt_word[8:3];
            third_pll_alt_div_p_out <= alt_word[2:0];
            third_pll_alt_vco_band_out <= regs[3][1:0];
            active_setting_out <= next_active;
            fourth_pll_spread_code_out <= next_code;
            spread_amount_out <= spread_amount(next_code);
            center_spread_out <= center_spread_in;
            fourth_pll_set_choice_out <= next_choice;
        end
    end
endmodule // pll_ssc_freq_select_config

// file: pll_cfg_sva.sv
// Port checker for the PLL configuration slice.
// Assumes it is bound to the slice top module.
`timescale 1ns/1ps
module pll_cfg_sva
    import pll_cfg_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic setting_pin_lsb_in,
    input wire logic setting_pin_mid_in,
    input wire logic setting_pin_msb_in,
    input wire logic center_spread_in,
    input wire logic [2:0] active_setting_out,
    input wire logic [CODE_W-1:0] fourth_pll_spread_code_out,
    input wire logic [7:0] spread_amount_out,
    input wire logic center_spread_out
);
    localparam logic [7:0] AMT [8] = '{8'h00, 8'h19, 8'h32, 8'h4B, 8'h64, 8'h7D, 8'h96, 8'hC8};
    logic [2:0] up_cnt;
    logic acc;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    assign acc = psel && penable && !pready;
    // Counts edges since reset so the pin path has filled.
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) up_cnt <= 3'h0;
        else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
    end
    pin_index_a: assert property (up_cnt > 3'h3 |-> active_setting_out ==
        $past({setting_pin_msb_in, setting_pin_mid_in, setting_pin_lsb_in}, 3))
        else $error("active setting wrong");
    spread_amt_a: assert property (spread_amount_out == AMT[fourth_pll_spread_code_out])
        else $error("spread amount wrong");
    center_pass_a: assert property (up_cnt > 3'h1 |-> center_spread_out == $past(center_spread_in))
        else $error("center bit wrong");
    ready_next_a: assert property (acc |=> pready) else $error("no ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    err_qual_a: assert property (pslverr |-> pready && $past(psel && penable))
        else $error("stray error");
    unmapped_err_a: assert property (acc && (paddr[9:2] < IDX_P3_N_HIGH
        || paddr[9:2] > IDX_STATUS) |=> pslverr) else $error("unmapped accepted");
    status_ro_a: assert property (acc && pwrite && paddr[9:2] == IDX_STATUS |=> pslverr)
        else $error("status write accepted");
    byte_only_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule // pll_cfg_sva
bind pll_ssc_freq_select_config pll_cfg_sva i_pll_cfg_sva (.*);

// file: pll_pin_host.sv
// Model of the external setting pins driven by the host.
// Assumes the bench asks for an index just after a clock edge.
`timescale 1ns/1ps
module pll_pin_host (
    input wire logic clk_in,
    input wire logic [2:0] want_in,
    output logic lsb_out = 1'b0,
    output logic mid_out = 1'b0,
    output logic msb_out = 1'b0
);
    // Puts the index on the pins, third pin most significant.
    always @(posedge clk_in) {msb_out, mid_out, lsb_out} <= want_in;
endmodule // pll_pin_host

// file: pll_ssc_freq_select_config_tb_top.sv
// Self-checking bench for the PLL configuration slice.
// Assumes one wait state on APB and three edges of pin latency.
`timescale 1ns/1ps
module pll_ssc_freq_select_config_tb_top import pll_cfg_pkg::*; ;
    localparam logic [7:0] AMT [8] = '{8'h00, 8'h19, 8'h32, 8'h4B, 8'h64, 8'h7D, 8'h96, 8'hC8};
    localparam logic [7:0] RSTV [8] = '{8'h00, 8'h40, 8'h02, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ctr = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, pl, pm, ph, ch, cso;
    logic [2:0] want = 3'h0, act, code;
    logic [7:0] amt;
    logic [31:0] word;
    logic [9:0] e;
    logic [9:0] exp_q [$];
    logic [7:0] regs [8];
    int bad_count = 0, comparisons = 0, seed = 40399;
    always #5 mclk = ~mclk;
    pll_ssc_freq_select_config i_pll_ssc_freq_select_config (.mclk_in(mclk), .arst_n_in(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .setting_pin_lsb_in(pl), .setting_pin_mid_in(pm), .setting_pin_msb_in(ph),
        .center_spread_in(ctr), .third_pll_alt_mult_n_out(word[31:20]),
        .third_pll_alt_frac_r_out(word[19:11]), .third_pll_alt_div_q_out(word[10:5]),
        .third_pll_alt_div_p_out(word[4:2]), .third_pll_alt_vco_band_out(word[1:0]),
        .active_setting_out(act), .fourth_pll_spread_code_out(code), .spread_amount_out(amt),
        .center_spread_out(cso), .fourth_pll_set_choice_out(ch));
    pll_pin_host i_pll_pin_host (.clk_in(mclk), .want_in(want), .lsb_out(pl), .mid_out(pm),
        .msb_out(ph));
    task automatic end_of_test();
        if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
        comparisons++;
        if (got !== exp_v) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp_v);
        end
    endtask
    // Compares the values copied in at the call, at the falling edge, then realigns to the rising edge.
    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp_v);
        @(negedge mclk) chk(got, exp_v);
        @(posedge mclk);
    endtask
    // One APB transfer; the expected answer is queued for the monitor.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
        input logic err);
        int k;
        exp_q.push_back({wr, err, d});
        psel <= 1'b1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
        @(posedge mclk) penable <= 1'b1;
        k = 0;
        do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin bad_count++; end_of_test(); end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask
    // Compares each APB answer with the oldest queued note.
    always @(posedge mclk) begin
        if (pready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk({31'h0, pslverr}, {31'h0, e[8]});
            if (!e[9] && !e[8]) chk(prdata, {24'h0, e[7:0]});
        end
    end
    // Main sequence: reset values, packing, pin selection, refusals.
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 8; i++) apb(1'b0, 8'h3C + 8'(i), RSTV[i], 1'b0);
        chk_out(word, 32'h0040_0208);
        for (int i = 0; i < 4; i++) regs[i] = 8'($random(seed));
        regs[0][0] = 1'b1;
        regs[2][2] = 1'b1;
        regs[4] = 8'hFA; regs[5] = 8'hC6; regs[6] = 8'h88; regs[7] = 8'($random(seed));
        for (int i = 0; i < 8; i++) apb(1'b1, 8'h3C + 8'(i), regs[i], 1'b0);
        for (int i = 0; i < 8; i++) apb(1'b0, 8'h3C + 8'(i), regs[i], 1'b0);
        chk_out(word, {regs[0], regs[1], regs[2], regs[3]});
        pstrb <= 4'h0;
        apb(1'b1, IDX_P3_N_HIGH, ~regs[0], 1'b0);
        pstrb <= 4'hF;
        apb(1'b0, IDX_P3_N_HIGH, regs[0], 1'b0);
        for (int k = 0; k < 8; k++) begin
            want <= 3'(k ^ 5);
            ctr <= 1'($random(seed));
            repeat (5) @(posedge mclk);
            chk_out({16'h0, act, code, amt, ch, cso},
                {16'h0, 3'(k ^ 5), 3'(k ^ 5), AMT[k ^ 5], regs[7][k ^ 5], ctr});
        end
        apb(1'b0, IDX_STATUS, 8'h02, 1'b0);
        apb(1'b0, 8'h10, 8'h00, 1'b1);
        apb(1'b1, IDX_STATUS, 8'h5A, 1'b1);
        apb(1'b0, 8'h45, 8'h00, 1'b1);
        repeat (3) @(posedge mclk);
        end_of_test();
    end
endmodule // pll_ssc_freq_select_config_tb_top
